/* File: core/spi_cfg_pkg.sv */
/*
  Constants and types for the three-wire serial configuration port.
  Assumes a 13-bit register address space and byte-wide registers.
*/
package spi_cfg_pkg;
  localparam int ADDR_W = 13;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam int RW_POS = 15;
  localparam int LEN_HI_POS = 14;
  localparam int LEN_LO_POS = 13;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  localparam logic [12:0] CFG_ADDR = 13'h000;
  localparam logic [12:0] CHLO_ADDR = 13'h004;
  localparam logic [12:0] CHHI_ADDR = 13'h005;
  localparam logic [12:0] GAIN_ADDR = 13'h011;
  localparam logic [12:0] CHIPM_ADDR = 13'h115;
  localparam logic [12:0] PROF_IDX_ADDR = 13'h10C;
  localparam logic [12:0] CFG_HI_ADDR = 13'h19E;
  localparam logic [12:0] PROF_LO_ADDR = 13'hF00;
  localparam logic [12:0] PROF_HI_ADDR = 13'hFFF;
  localparam logic [12:0] LOCAL_LO_ADDR = 13'h006;
  localparam logic [12:0] LOCAL_HI_ADDR = 13'h0FF;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CHLO_RST = 8'h0F;
  localparam logic [7:0] CHHI_RST = 8'h3F;
  localparam logic [7:0] GAIN_RST = 8'h06;
  localparam logic [7:0] CHIPM_RST = 8'h00;
  localparam logic [7:0] CFG_LSB_MASK = 8'h42;
  localparam logic [7:0] CFG_SRST_MASK = 8'h24;
  localparam int CHIPM_IGN_BIT = 0;
  localparam logic [2:0] PROF_CLKS = 3'h4;
  typedef enum logic [0:0] {
    PH_INSTR = 1'b0,
    PH_DATA = 1'b1
  } phase_type;
endpackage

/* File: core/bit_sync3.sv */
/*
  Three-stage level synchroniser; a change is taken once stages two and three agree.
  Assumes the input is a slow level from another clock domain.
*/
`timescale 1ns/100ps
module bit_sync3 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sync_state_type;
  sync_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = d_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.q = s_q.s3;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.q;
endmodule

/* File: core/sdio_edge_stage.sv */
/*
  Falling-edge output stage for the serial data pin.
  Assumes next bit and enable are prepared on the rising edge.
*/
`timescale 1ns/100ps
module sdio_edge_stage (
  input wire logic sclk_i,
  input wire logic rst_i,
  input wire logic oe_i,
  input wire logic bit_i,
  output logic oe_o,
  output logic bit_o
);
  typedef struct packed {
    logic oe;
    logic dat;
  } edge_state_type;
  edge_state_type e_q, e_d;

  always_comb begin
    e_d.oe = oe_i;
    e_d.dat = bit_i;
  end

  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      e_q <= '0;
    end else begin
      e_q <= e_d;
    end
  end

  assign oe_o = e_q.oe;
  assign bit_o = e_q.dat;
endmodule

/* File: core/spi_config_port.sv */
/*
  Serial configuration port: frame engine and held registers on the serial clock,
  write and profile-load events handed to the system clock by toggle crossings.
  Assumes the host meets setup and hold to the serial clock on select and data,
  and leaves at least one byte time between forwarded writes.
*/
`timescale 1ns/100ps
module spi_config_port
  import spi_cfg_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SCLK_I,
  input wire logic SELECT_N_I,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE_O,
  output logic WR_STB_O,
  output logic [12:0] WR_ADDR_O,
  output logic [7:0] WR_DATA_O,
  output logic [15:0] WR_CHAN_O,
  output logic WR_LOCAL_O,
  output logic [7:0] GAIN_O,
  output logic PROFILE_LOAD_O
);
  typedef struct packed {
    phase_type phase;
    logic [3:0] bit_cnt;
    logic [15:0] shift;
    logic rw;
    logic [1:0] len;
    logic [12:0] addr;
    logic [1:0] bytes_left;
    logic rd_act;
    logic [7:0] tx_byte;
    logic [7:0] cfg;
    logic [7:0] chlo;
    logic [7:0] chhi;
    logic [7:0] gain;
    logic [7:0] chipm;
    logic [12:0] x_addr;
    logic [7:0] x_data;
    logic [15:0] x_chan;
    logic x_local;
    logic x_fwd;
    logic wr_tgl;
    logic [2:0] prof_cnt;
    logic prof_tgl;
  } link_state_type;

  typedef struct packed {
    logic wr_seen;
    logic prof_seen;
    logic wr_stb;
    logic prof_stb;
    logic [12:0] wr_addr;
    logic [7:0] wr_data;
    logic [15:0] wr_chan;
    logic wr_local;
    logic [7:0] gain;
  } core_state_type;

  link_state_type l_q, l_d;
  core_state_type c_q, c_d;
  logic gap_q;
  logic lsb;
  logic oe_neg;
  logic bit_neg;
  logic tx_bit;
  logic wr_sync;
  logic prof_sync;
  logic wr_chip_blk;
  logic wr_prof;
  logic [12:0] addr_up;
  logic [12:0] addr_dn;

  function automatic logic [7:0] rd_mux(input link_state_type s, input logic [12:0] a);
    case (a)
      CFG_ADDR: rd_mux = s.cfg;
      CHLO_ADDR: rd_mux = s.chlo;
      CHHI_ADDR: rd_mux = s.chhi;
      GAIN_ADDR: rd_mux = s.gain;
      CHIPM_ADDR: rd_mux = s.chipm;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  assign lsb = |(l_q.cfg & CFG_LSB_MASK);
  assign addr_up = l_q.addr + 13'h0001;
  assign addr_dn = l_q.addr - 13'h0001;

  // Set while select is high; tells the next rising edge that a gap came before it.
  // Select acts as an asynchronous set because the serial clock may be stopped.
  always_ff @(posedge SCLK_I or posedge RST_I or posedge SELECT_N_I) begin
    if (RST_I || SELECT_N_I) begin
      gap_q <= 1'b1;
    end else begin
      gap_q <= 1'b0;
    end
  end

  always_comb begin
    logic [15:0] word;
    logic [7:0] wd;
    logic [3:0] cnt;
    logic local_reg;
    logic in_region;
    logic accept;
    word = '0;
    wd = '0;
    cnt = l_q.bit_cnt;
    local_reg = 1'b0;
    in_region = 1'b0;
    accept = 1'b0;
    wr_chip_blk = 1'b0;
    wr_prof = 1'b0;
    l_d = l_q;
    if (!SELECT_N_I) begin
      if (l_q.prof_cnt != 3'h0) begin
        l_d.prof_cnt = l_q.prof_cnt - 3'h1;
        if (l_q.prof_cnt == 3'h1) begin
          l_d.prof_tgl = ~l_q.prof_tgl;
        end
      end
      if (gap_q && l_q.bit_cnt != 4'h0) begin
        cnt = 4'h0;
        l_d.phase = PH_INSTR;
        l_d.rd_act = 1'b0;
      end else if (gap_q && l_q.phase == PH_DATA && l_q.len == LEN_STREAM) begin
        l_d.phase = PH_INSTR;
        l_d.rd_act = 1'b0;
      end
      word = lsb ? {SDIO_I, l_q.shift[15:1]} : {l_q.shift[14:0], SDIO_I};
      l_d.shift = word;
      if (l_d.phase == PH_INSTR) begin
        if (cnt == INSTR_LAST) begin
          l_d.rw = word[RW_POS];
          l_d.len = word[LEN_HI_POS:LEN_LO_POS];
          l_d.addr = word[ADDR_W-1:0];
          l_d.bytes_left = word[LEN_HI_POS:LEN_LO_POS];
          l_d.phase = PH_DATA;
          l_d.bit_cnt = 4'h0;
          l_d.rd_act = word[RW_POS];
          l_d.tx_byte = rd_mux(l_q, word[ADDR_W-1:0]);
        end else begin
          l_d.bit_cnt = cnt + 4'h1;
        end
      end else if (cnt == BYTE_LAST) begin
        wd = lsb ? word[15:8] : word[7:0];
        l_d.bit_cnt = 4'h0;
        if (!l_q.rw) begin
          in_region = (l_q.addr <= CFG_HI_ADDR) ||
            (l_q.addr >= PROF_LO_ADDR && l_q.addr <= PROF_HI_ADDR);
          local_reg = l_q.addr >= LOCAL_LO_ADDR && l_q.addr <= LOCAL_HI_ADDR;
          case (l_q.addr)
            CFG_ADDR: begin
              if (|(wd & CFG_SRST_MASK)) begin
                l_d.cfg = CFG_RST;
                l_d.chlo = CHLO_RST;
                l_d.chhi = CHHI_RST;
                l_d.gain = GAIN_RST;
                l_d.chipm = CHIPM_RST;
              end else begin
                l_d.cfg = wd;
              end
              accept = 1'b1;
            end
            CHLO_ADDR: begin
              l_d.chlo = wd;
              accept = 1'b1;
            end
            CHHI_ADDR: begin
              l_d.chhi = wd;
              accept = 1'b1;
            end
            GAIN_ADDR: begin
              l_d.gain = wd;
              accept = 1'b1;
            end
            CHIPM_ADDR: begin
              l_d.chipm = wd;
              accept = 1'b1;
            end
            default: begin
              if (in_region && local_reg) begin
                accept = |{l_q.chhi, l_q.chlo};
              end else if (in_region) begin
                accept = !l_q.chipm[CHIPM_IGN_BIT];
                wr_chip_blk = l_q.chipm[CHIPM_IGN_BIT];
              end
              l_d.x_fwd = 1'b1;
            end
          endcase
          if (accept) begin
            l_d.x_addr = l_q.addr;
            l_d.x_data = wd;
            l_d.x_chan = local_reg ? {l_q.chhi, l_q.chlo} : 16'hFFFF;
            l_d.x_local = local_reg;
            l_d.x_fwd = in_region && !(l_q.addr == CFG_ADDR || l_q.addr == CHLO_ADDR ||
              l_q.addr == CHHI_ADDR || l_q.addr == GAIN_ADDR || l_q.addr == CHIPM_ADDR);
            l_d.wr_tgl = ~l_q.wr_tgl;
            if (l_q.addr == PROF_IDX_ADDR) begin
              l_d.prof_cnt = PROF_CLKS;
              wr_prof = 1'b1;
            end
          end else begin
            l_d.x_fwd = l_q.x_fwd;
          end
        end
        l_d.addr = lsb ? addr_up : addr_dn;
        if (l_q.len != LEN_STREAM && l_q.bytes_left == 2'h0) begin
          l_d.phase = PH_INSTR;
          l_d.rd_act = 1'b0;
        end else begin
          if (l_q.len != LEN_STREAM) begin
            l_d.bytes_left = l_q.bytes_left - 2'h1;
          end
          l_d.tx_byte = rd_mux(l_d, lsb ? addr_up : addr_dn);
        end
      end else begin
        l_d.bit_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge SCLK_I or posedge RST_I) begin
    if (RST_I) begin
      l_q <= '0;
      l_q.cfg <= CFG_RST;
      l_q.chlo <= CHLO_RST;
      l_q.chhi <= CHHI_RST;
      l_q.gain <= GAIN_RST;
      l_q.chipm <= CHIPM_RST;
    end else begin
      l_q <= l_d;
    end
  end

  assign tx_bit = lsb ? l_q.tx_byte[l_q.bit_cnt[2:0]] : l_q.tx_byte[3'h7 - l_q.bit_cnt[2:0]];

  sdio_edge_stage u_edge (
    .sclk_i(SCLK_I),
    .rst_i(RST_I),
    .oe_i(l_q.rd_act),
    .bit_i(tx_bit),
    .oe_o(oe_neg),
    .bit_o(bit_neg)
  );

  // Release follows the rising edge that ends the read, not the next falling edge
  assign SDIO_OE_O = oe_neg & l_q.rd_act & ~SELECT_N_I &
    ~(gap_q & ((l_q.len == LEN_STREAM) || (l_q.bit_cnt != 4'h0)));
  assign SDIO_O = bit_neg;

  bit_sync3 u_wr_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(l_q.wr_tgl),
    .q_o(wr_sync)
  );

  bit_sync3 u_prof_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(l_q.prof_tgl),
    .q_o(prof_sync)
  );

  // Snapshot fields are quiet for a whole byte time after each toggle
  always_comb begin
    c_d = c_q;
    c_d.wr_stb = 1'b0;
    c_d.prof_stb = 1'b0;
    if (wr_sync != c_q.wr_seen) begin
      c_d.wr_seen = wr_sync;
      c_d.wr_stb = l_q.x_fwd;
      c_d.wr_addr = l_q.x_addr;
      c_d.wr_data = l_q.x_data;
      c_d.wr_chan = l_q.x_chan;
      c_d.wr_local = l_q.x_local;
      c_d.gain = l_q.gain;
    end
    if (prof_sync != c_q.prof_seen) begin
      c_d.prof_seen = prof_sync;
      c_d.prof_stb = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      c_q <= '0;
      c_q.gain <= GAIN_RST;
    end else begin
      c_q <= c_d;
    end
  end

  assign WR_STB_O = c_q.wr_stb;
  assign WR_ADDR_O = c_q.wr_addr;
  assign WR_DATA_O = c_q.wr_data;
  assign WR_CHAN_O = c_q.wr_chan;
  assign WR_LOCAL_O = c_q.wr_local;
  assign GAIN_O = c_q.gain;
  assign PROFILE_LOAD_O = c_q.prof_stb;

  sequence s_instr_end;
    !SELECT_N_I && !gap_q && l_q.phase == PH_INSTR && l_q.bit_cnt == INSTR_LAST;
  endsequence

  sequence s_last_byte_end;
    !SELECT_N_I && !gap_q && l_q.phase == PH_DATA && l_q.bit_cnt == BYTE_LAST &&
      l_q.len != LEN_STREAM && l_q.bytes_left == 2'h0;
  endsequence

  a_instr_to_data: assert property (@(posedge SCLK_I) disable iff (RST_I)
    s_instr_end |=> l_q.phase == PH_DATA && l_q.bit_cnt == 4'h0)
    else $error("instruction end did not enter data phase");

  a_read_turn: assert property (@(posedge SCLK_I) disable iff (RST_I)
    s_instr_end ##1 (l_q.rw && !SELECT_N_I && !gap_q) |-> SDIO_OE_O)
    else $error("read did not enable data output");

  a_oe_release: assert property (@(posedge SCLK_I) disable iff (RST_I)
    s_last_byte_end |=> !SDIO_OE_O && l_q.phase == PH_INSTR)
    else $error("data output not released after last byte");

  a_select_ignore: assert property (@(posedge SCLK_I) disable iff (RST_I)
    SELECT_N_I |=> $stable(l_q.bit_cnt) && $stable(l_q.wr_tgl))
    else $error("state changed while select high");

  a_abort_drop: assert property (@(posedge SCLK_I) disable iff (RST_I)
    (!SELECT_N_I && gap_q && l_q.bit_cnt != 4'h0) |=>
      l_q.phase == PH_INSTR && l_q.bit_cnt == 4'h1)
    else $error("partial byte did not restart instruction");

  a_byte_resume: assert property (@(posedge SCLK_I) disable iff (RST_I)
    (!SELECT_N_I && gap_q && l_q.phase == PH_DATA && l_q.bit_cnt == 4'h0 &&
      l_q.len != LEN_STREAM) |=> l_q.phase == PH_DATA && l_q.bit_cnt == 4'h1)
    else $error("paused short transfer did not resume");

  a_stream_hold: assert property (@(posedge SCLK_I) disable iff (RST_I)
    (!SELECT_N_I && !gap_q && l_q.phase == PH_DATA && l_q.len == LEN_STREAM &&
      l_q.bit_cnt == BYTE_LAST) |=> l_q.phase == PH_DATA)
    else $error("stream left data phase without select high");

  a_addr_step: assert property (@(posedge SCLK_I) disable iff (RST_I)
    (!SELECT_N_I && !gap_q && l_q.phase == PH_DATA && l_q.bit_cnt == BYTE_LAST) |=>
      l_q.addr == ($past(lsb) ? $past(addr_up) : $past(addr_dn)))
    else $error("address not stepped after byte");

  a_chip_gate: assert property (@(posedge SCLK_I) disable iff (RST_I)
    wr_chip_blk |=> $stable(l_q.wr_tgl))
    else $error("ignored chip write was forwarded");

  a_profile_load: assert property (@(posedge SCLK_I) disable iff (RST_I)
    wr_prof ##1 (!SELECT_N_I && !wr_prof) [*4] |=> l_q.prof_tgl != $past(l_q.prof_tgl, 5))
    else $error("profile load not raised four clocks after index write");

  a_gain_reset: assert property (@(posedge CLK_I)
    $fell(RST_I) |-> GAIN_O == GAIN_RST)
    else $error("gain output not at reset default");

  a_strobe_pulse: assert property (@(posedge CLK_I) disable iff (RST_I)
    WR_STB_O |=> !WR_STB_O)
    else $error("write strobe longer than one cycle");
endmodule

/* File: tb/spi_host_model.sv */
/*
  Behavioural host for the serial port: makes the serial clock, select and data.
  Assumes the bench resolves the shared data line from both enables.
*/
`timescale 1ns/100ps
module spi_host_model (
  output logic sclk_o,
  output logic select_n_o,
  output logic sd_o,
  output logic sd_oe_o,
  input wire logic sd_i
);
  logic [7:0] wd [8];
  logic [7:0] rd [8];
  initial begin
    sclk_o = 1'b0;
    select_n_o = 1'b1;
    sd_o = 1'b0;
    sd_oe_o = 1'b0;
  end
  // Clock stands low between frames; released line toggles so stale bits never match
  task automatic shift(input logic [15:0] v, input int n, input bit lsb, input bit drv,
      output logic [15:0] r);
    int k;
    r = '0;
    for (int i = 0; i < n; i++) begin
      k = lsb ? i : n - 1 - i;
      sd_oe_o = drv;
      sd_o = drv ? v[k] : ~sd_o;
      #62.5;
      r[k] = sd_i;
      sclk_o = 1'b1;
      #62.5;
      sclk_o = 1'b0;
    end
  endtask
  task automatic frame(input logic rw, input logic [1:0] len, input logic [12:0] a,
      input int nb, input bit lsb, input int pause, input int cut);
    logic [15:0] r;
    select_n_o = 1'b0;
    #62.5;
    shift({rw, len, a}, 16, lsb, 1'b1, r);
    for (int b = 0; b < nb; b++) begin
      if (pause > 0 && b > 0) begin
        select_n_o = 1'b1;
        #(pause * 62.5);
        select_n_o = 1'b0;
        #62.5;
      end
      shift({8'h00, wd[b]}, (b == cut) ? 4 : 8, lsb, !rw, r);
      rd[b] = r[7:0];
      if (b == cut) break;
    end
    #62.5;
    select_n_o = 1'b1;
    sd_oe_o = 1'b0;
  endtask
  // Clocks and data with select high must leave the port untouched
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      sd_oe_o = 1'b1;
      sd_o = i[0];
      #62.5;
      sclk_o = 1'b1;
      #62.5;
      sclk_o = 1'b0;
    end
    sd_oe_o = 1'b0;
  endtask
endmodule

/* File: tb/tb.sv */
/*
  Bench for the serial configuration port: host model on the serial side,
  forwarded writes and profile loads logged on the system side.
  Assumes the package, design files and host model are compiled first.
*/
`timescale 1ns/100ps
module tb;
  import spi_cfg_pkg::*;
  logic clk;
  logic rst;
  logic lsb;
  logic [7:0] d;
  wire sclk, sel_n, h_sd, h_oe, sdio_o, sdio_oe, wr_stb, wr_loc, prof;
  wire [12:0] wr_addr;
  wire [7:0] wr_data, gain;
  wire [15:0] wr_chan;
  wire line = (sdio_oe === 1'b1) ? sdio_o : (h_oe ? h_sd : ~h_sd);
  int n_errors, cmp_count, n_wr, n_prof;
  logic [12:0] la [64];
  logic [7:0] ld [64];
  logic [15:0] lc [64];
  logic ll [64];
  spi_host_model host (.sclk_o(sclk), .select_n_o(sel_n), .sd_o(h_sd), .sd_oe_o(h_oe),
    .sd_i(line));
  spi_config_port dut (.CLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .SELECT_N_I(sel_n),
    .SDIO_I(line), .SDIO_O(sdio_o), .SDIO_OE_O(sdio_oe), .WR_STB_O(wr_stb),
    .WR_ADDR_O(wr_addr), .WR_DATA_O(wr_data), .WR_CHAN_O(wr_chan), .WR_LOCAL_O(wr_loc),
    .GAIN_O(gain), .PROFILE_LOAD_O(prof));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Mid-cycle sampling keeps the log clear of the launching edge
  always @(negedge clk) begin
    if (wr_stb === 1'b1) begin
      la[n_wr % 64] = wr_addr;
      ld[n_wr % 64] = wr_data;
      lc[n_wr % 64] = wr_chan;
      ll[n_wr % 64] = wr_loc;
      n_wr++;
    end
    if (prof === 1'b1) n_prof++;
  end
  task check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task print_verdict;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Ten system cycles cover the four to five cycle crossing
  task go(input logic rw, input logic [1:0] len, input logic [12:0] a, input int nb,
      input int pause, input int cut);
    host.frame(rw, len, a, nb, lsb, pause, cut);
    repeat (10) @(posedge clk);
    #1;
  endtask
  task wr1(input logic [12:0] a, input logic [7:0] v);
    host.wd[0] = v;
    go(1'b0, 2'b00, a, 1, 0, -1);
  endtask
  task rd1(input logic [12:0] a);
    go(1'b1, 2'b00, a, 1, 0, -1);
    d = host.rd[0];
  endtask
  task exp_wr(input int i, input logic [12:0] a, input logic [7:0] v);
    check(16'(la[i % 64]), 16'(a));
    check(16'(ld[i % 64]), 16'(v));
  endtask
  task t_reset;
    logic [12:0] a [5] = '{CFG_ADDR, CHLO_ADDR, CHHI_ADDR, GAIN_ADDR, CHIPM_ADDR};
    logic [7:0] e [5] = '{CFG_RST, CHLO_RST, CHHI_RST, GAIN_RST, CHIPM_RST};
    check(16'(gain), 16'h0006);
    for (int i = 0; i < 5; i++) begin
      rd1(a[i]);
      check(16'(d), 16'(e[i]));
    end
    check(16'(sdio_oe), 16'h0000);
  endtask
  task t_held;
    wr1(GAIN_ADDR, 8'h5A);
    rd1(GAIN_ADDR);
    check(16'(d), 16'h005A);
    check(16'(gain), 16'h005A);
  endtask
  task t_local;
    int n0;
    n0 = n_wr;
    wr1(13'h020, 8'h33);
    exp_wr(n0, 13'h020, 8'h33);
    check(lc[n0 % 64], {CHHI_RST, CHLO_RST});
    check(16'(ll[n0 % 64]), 16'h0001);
    wr1(CHLO_ADDR, 8'h00);
    wr1(CHHI_ADDR, 8'h00);
    wr1(13'h020, 8'h44);
    check(16'(n_wr - n0), 16'h0001);
    wr1(CHLO_ADDR, 8'h05);
    wr1(13'h0FF, 8'h45);
    check(lc[(n0 + 1) % 64], 16'h0005);
  endtask
  task t_chip;
    logic [12:0] a [6] = '{13'h150, 13'h19E, 13'h19F, 13'hEFF, 13'hF00, 13'hFFF};
    logic hit [6] = '{1, 1, 0, 0, 1, 1};
    int n0;
    for (int i = 0; i < 6; i++) begin
      n0 = n_wr;
      wr1(a[i], hit[i] ? 8'(i) : 8'h00);
      check(16'(n_wr - n0), 16'(hit[i]));
      if (hit[i]) begin
        exp_wr(n0, a[i], 8'(i));
        check(lc[n0 % 64], 16'hFFFF);
      end
    end
    wr1(CHIPM_ADDR, 8'h01);
    n0 = n_wr;
    wr1(13'h150, 8'h78);
    check(16'(n_wr - n0), 16'h0000);
    wr1(CHIPM_ADDR, 8'h00);
    wr1(13'h150, 8'h79);
    exp_wr(n0, 13'h150, 8'h79);
  endtask
  task t_multi;
    int n0;
    n0 = n_wr;
    host.wd = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
    go(1'b0, 2'b10, 13'h022, 3, 6, -1);
    check(16'(n_wr - n0), 16'h0003);
    for (int i = 0; i < 3; i++) exp_wr(n0 + i, 13'(13'h022 - i), host.wd[i]);
    n0 = n_wr;
    go(1'b0, 2'b11, 13'h030, 5, 0, -1);
    check(16'(n_wr - n0), 16'h0005);
    exp_wr(n0 + 4, 13'h02C, 8'h55);
    go(1'b1, 2'b11, CHHI_ADDR, 3, 0, -1);
    check({host.rd[0], host.rd[1]}, 16'h0005);
    check(16'(host.rd[2]), 16'h0000);
    host.select_n_o = 1'b0;
    #100;
    check(16'(sdio_oe), 16'h0000);
    host.select_n_o = 1'b1;
    #100;
  endtask
  task t_abort;
    int n0;
    n0 = n_wr;
    host.idle(20);
    host.wd[0] = 8'hC3;
    go(1'b0, 2'b00, 13'h040, 1, 0, 0);
    check(16'(n_wr - n0), 16'h0000);
    wr1(13'h041, 8'h5C);
    exp_wr(n0, 13'h041, 8'h5C);
  endtask
  task t_profile;
    int p0;
    p0 = n_prof;
    wr1(PROF_IDX_ADDR, 8'h02);
    check(16'(n_prof - p0), 16'h0000);
    rd1(GAIN_ADDR);
    check(16'(n_prof - p0), 16'h0001);
  endtask
  task t_lsb;
    int n0;
    wr1(CFG_ADDR, 8'h42);
    lsb = 1'b1;
    n0 = n_wr;
    host.wd[0] = 8'hA1;
    host.wd[1] = 8'hB2;
    go(1'b0, 2'b01, 13'h050, 2, 0, -1);
    exp_wr(n0, 13'h050, 8'hA1);
    exp_wr(n0 + 1, 13'h051, 8'hB2);
    rd1(GAIN_ADDR);
    check(16'(d), 16'h005A);
    wr1(CFG_ADDR, 8'h00);
    lsb = 1'b0;
    wr1(CFG_ADDR, 8'h24);
    rd1(GAIN_ADDR);
    check(16'(d), 16'(GAIN_RST));
  endtask
  initial begin
    rst = 1'b1;
    lsb = 1'b0;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    t_reset;
    t_held;
    t_local;
    t_chip;
    t_multi;
    t_abort;
    t_profile;
    t_lsb;
    print_verdict;
  end
  // Whole sequence needs about 130 us
  initial begin
    #500000;
    n_errors++;
    print_verdict;
  end
endmodule
